// ==== dsar_status_bank.v ====
`timescale 1ns/1ps
`include "dsar_regs.vh"

module dsar_status_bank #(
  parameter ACT_INTERVAL = `DSAR_ACT_INTERVAL_CYC
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Host record read port
  input wire rd_en,
  input wire [5:0] rd_index,
  output reg [7:0] rd_data,
  output reg rd_valid,
  // Host latched alarm clear
  input wire latch_clear,
  // Mode selects
  input wire legacy_mode,
  input wire intermediate_rate_service,
  // Live alarm sources
  input wire [7:0] rx_alarm_live,
  input wire [7:0] buffer_decoder_alarms,
  input wire [7:0] lock_status,
  // Monitored clocks, sampled
  input wire buffer_clk_in,
  input wire ext_conn_clk_in,
  input wire rx_sat_clk_in,
  input wire insert_clk_in,
  input wire ext_ref_clk_in,
  input wire hs_ref_clk_in,
  input wire rx_clk_fallback,
  input wire energy_per_bit_estimate_threshold_fault,
  // Common equipment
  input wire [2:0] supply_fail,
  input wire battery_fail,
  input wire memory_fail,
  input wire mc_proc_fault,
  input wire uio_card_present,
  input wire if_card_present,
  // Backward alarms
  input wire [3:0] backward_alarm_in,
  // Measurements
  input wire [31:0] bit_error_count_in,
  input wire [31:0] pattern_error_count_in,
  input wire [15:0] raw_mant_in,
  input wire [7:0] raw_exp_in,
  input wire [15:0] corr_mant_in,
  input wire [7:0] corr_exp_in,
  input wire [15:0] pat_mant_in,
  input wire [7:0] pat_exp_in,
  input wire [15:0] energy_per_bit_estimate_in,
  input wire [1:0] energy_per_bit_estimate_status_in,
  input wire [31:0] freq_mag_in,
  input wire freq_negative_in,
  input wire rates_valid_in,
  input wire pat_rate_valid_in,
  input wire err_cnt_overflow_in,
  input wire pat_cnt_overflow_in,
  input wire [7:0] buffer_fill_in,
  input wire [7:0] input_level_in
);

  ////////////////////////////////////////////////////////////////////////////
  // Byte n (0 = most significant) of a 32-bit word
  function [7:0] dsar_byte_of;
    input [31:0] word;
    input [1:0] n;
    begin
      case (n)
        2'h0: dsar_byte_of = word[31:24];
        2'h1: dsar_byte_of = word[23:16];
        2'h2: dsar_byte_of = word[15:8];
        default: dsar_byte_of = word[7:0];
      endcase
    end
  endfunction

  // True when idx lies in the len-byte field that starts at base
  function dsar_in_field;
    input [5:0] idx;
    input [5:0] base;
    input [2:0] len;
    begin
      dsar_in_field = (idx >= base) && (idx < base + {3'h0, len});
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Clock activity detection
  reg [5:0] clk_prev_reg;
  reg [5:0] toggle_seen_reg;
  reg [5:0] activity_reg;
  reg [15:0] interval_cnt_reg;
  reg sample_primed_reg;
  wire [5:0] clk_now;
  wire [5:0] toggled;
  wire interval_end;

  assign clk_now = {hs_ref_clk_in, ext_ref_clk_in, insert_clk_in,
                    rx_sat_clk_in, ext_conn_clk_in, buffer_clk_in};
  // No previous sample exists on the first cycle out of reset, so a pin
  // that idles high must not count as a toggle there
  assign toggled = (clk_now ^ clk_prev_reg) & {6{sample_primed_reg}};
  // A toggle on the closing cycle still counts toward the window it ends
  assign interval_end = (interval_cnt_reg == ACT_INTERVAL - 1);

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      clk_prev_reg <= 6'h00;
      toggle_seen_reg <= 6'h00;
      activity_reg <= 6'h00;
      interval_cnt_reg <= 16'h0000;
      sample_primed_reg <= 1'b0;
    end
    else
    begin
      clk_prev_reg <= clk_now;
      sample_primed_reg <= 1'b1;
      if (interval_end)
      begin
        interval_cnt_reg <= 16'h0000;
        activity_reg <= toggle_seen_reg | toggled;
        toggle_seen_reg <= 6'h00;
      end
      else
      begin
        interval_cnt_reg <= interval_cnt_reg + 16'h0001;
        toggle_seen_reg <= toggle_seen_reg | toggled;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latched alarms, set wins over clear
  reg [6:0] latch_rx_reg;
  reg [7:0] latch_bd_reg;
  reg [3:0] latch_lock_reg;
  reg [4:0] latch_supply_reg;
  reg [2:0] latch_equip_reg;
  wire [6:0] set_rx;
  wire [3:0] set_lock;
  wire [4:0] set_supply;
  wire [2:0] set_equip;

  // Live bit 6 reads 1 while data is present; the latch records its loss
  assign set_rx = {~rx_alarm_live[`DSAR_RX_DATA_ACTIVITY], rx_alarm_live[5:0]};
  assign set_lock = ~{lock_status[7], lock_status[2:0]};
  assign set_supply = {memory_fail, battery_fail, supply_fail};
  assign set_equip = {~if_card_present, ~uio_card_present, mc_proc_fault};

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      latch_rx_reg <= 7'h00;
      latch_bd_reg <= 8'h00;
      latch_lock_reg <= 4'h0;
      latch_supply_reg <= 5'h00;
      latch_equip_reg <= 3'h0;
    end
    // Clear reloads with this cycle's faults, so a live fault survives it
    else if (latch_clear)
    begin
      latch_rx_reg <= set_rx;
      latch_bd_reg <= buffer_decoder_alarms;
      latch_lock_reg <= set_lock;
      latch_supply_reg <= set_supply;
      latch_equip_reg <= set_equip;
    end
    else
    begin
      latch_rx_reg <= latch_rx_reg | set_rx;
      latch_bd_reg <= latch_bd_reg | buffer_decoder_alarms;
      latch_lock_reg <= latch_lock_reg | set_lock;
      latch_supply_reg <= latch_supply_reg | set_supply;
      latch_equip_reg <= latch_equip_reg | set_equip;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status record bytes
  reg [7:0] clock_activity_alarms;
  wire [7:0] common_supply_alarms;
  wire [7:0] common_equipment_alarms;
  wire [7:0] latched_receive_alarms;
  wire [7:0] latched_lock_alarms;
  wire [7:0] latched_supply_alarms;
  wire [7:0] latched_equipment_alarms;
  wire [7:0] backward_alarm_flags;
  wire [7:0] quality_measure_status;
  wire [7:0] buffer_fill_percent;
  wire [7:0] frequency_offset_sign;

  // Activity byte, field by field; external clock bits read 0 in legacy mode
  always @*
  begin
    clock_activity_alarms = `DSAR_RESET_BYTE;
    clock_activity_alarms[`DSAR_ACT_BUFFER] = activity_reg[0];
    clock_activity_alarms[`DSAR_ACT_EXT_CONN] = activity_reg[1] & ~legacy_mode;
    clock_activity_alarms[`DSAR_ACT_RX_SAT] = activity_reg[2];
    clock_activity_alarms[`DSAR_ACT_INSERT] = activity_reg[3];
    clock_activity_alarms[`DSAR_ACT_EXT_REF] = activity_reg[4] & ~legacy_mode;
    clock_activity_alarms[`DSAR_ACT_HS_REF] = activity_reg[5] & ~legacy_mode;
    clock_activity_alarms[`DSAR_ACT_FALLBACK] = rx_clk_fallback;
    clock_activity_alarms[`DSAR_ACT_ENERGY_PER_BIT_ESTIMATE_THR] = energy_per_bit_estimate_threshold_fault;
  end
  assign common_supply_alarms = {2'h0, memory_fail, battery_fail, 1'b0,
                                 supply_fail};
  assign common_equipment_alarms = {5'h00, if_card_present,
                                    uio_card_present & ~legacy_mode,
                                    mc_proc_fault};
  assign latched_receive_alarms = {rx_alarm_live[`DSAR_RX_GAIN_LEVEL],
                                   latch_rx_reg};
  assign latched_lock_alarms = {latch_lock_reg[3], lock_status[6:3],
                                latch_lock_reg[2:0]};
  assign latched_supply_alarms = {2'h0, latch_supply_reg[4:3], 1'b0,
                                  latch_supply_reg[2:0]};
  assign latched_equipment_alarms = {5'h00, latch_equip_reg[2],
                                     latch_equip_reg[1] & ~legacy_mode,
                                     latch_equip_reg[0]};
  assign backward_alarm_flags = {4'h0,
                                 backward_alarm_in[3:1] & {3{intermediate_rate_service}},
                                 backward_alarm_in[0]};
  assign quality_measure_status = {2'h0, pat_cnt_overflow_in, err_cnt_overflow_in,
                                   energy_per_bit_estimate_status_in,
                                   pat_rate_valid_in, rates_valid_in};
  // A fill source that overshoots is reported as full
  assign buffer_fill_percent = (buffer_fill_in > `DSAR_FILL_MAX) ?
                               `DSAR_FILL_MAX : buffer_fill_in;
  assign frequency_offset_sign = {7'h00, freq_negative_in};

  ////////////////////////////////////////////////////////////////////////////
  // Record read mux
  reg [7:0] rd_byte;
  reg [5:0] rel;

  always @*
  begin
    rd_byte = `DSAR_RESET_BYTE;
    rel = 6'h00;
    if (dsar_in_field(rd_index, `DSAR_IDX_BIT_ERR_CNT, 3'h4))
    begin
      rel = rd_index - `DSAR_IDX_BIT_ERR_CNT;
      rd_byte = dsar_byte_of(bit_error_count_in, rel[1:0]);
    end
    else if (dsar_in_field(rd_index, `DSAR_IDX_PAT_ERR_CNT, 3'h4))
    begin
      rel = rd_index - `DSAR_IDX_PAT_ERR_CNT;
      rd_byte = dsar_byte_of(pattern_error_count_in, rel[1:0]);
    end
    else if (dsar_in_field(rd_index, `DSAR_IDX_FREQ_MAG, 3'h4))
    begin
      rel = rd_index - `DSAR_IDX_FREQ_MAG;
      rd_byte = dsar_byte_of(freq_mag_in, rel[1:0]);
    end
    // Two-byte fields are read as the low half of a zero-extended word
    else if (dsar_in_field(rd_index, `DSAR_IDX_RAW_MANT, 3'h2))
    begin
      rel = rd_index - `DSAR_IDX_RAW_MANT;
      rd_byte = dsar_byte_of({16'h0000, raw_mant_in}, {1'b1, rel[0]});
    end
    else if (dsar_in_field(rd_index, `DSAR_IDX_CORR_MANT, 3'h2))
    begin
      rel = rd_index - `DSAR_IDX_CORR_MANT;
      rd_byte = dsar_byte_of({16'h0000, corr_mant_in}, {1'b1, rel[0]});
    end
    else if (dsar_in_field(rd_index, `DSAR_IDX_ENERGY_PER_BIT_ESTIMATE, 3'h2))
    begin
      rel = rd_index - `DSAR_IDX_ENERGY_PER_BIT_ESTIMATE;
      rd_byte = dsar_byte_of({16'h0000, energy_per_bit_estimate_in}, {1'b1, rel[0]});
    end
    else if (dsar_in_field(rd_index, `DSAR_IDX_PAT_MANT, 3'h2))
    begin
      rel = rd_index - `DSAR_IDX_PAT_MANT;
      rd_byte = dsar_byte_of({16'h0000, pat_mant_in}, {1'b1, rel[0]});
    end
    else
    begin
      case (rd_index)
        `DSAR_IDX_CLOCK_ACTIVITY: rd_byte = clock_activity_alarms;
        `DSAR_IDX_COMMON_SUPPLY: rd_byte = common_supply_alarms;
        `DSAR_IDX_COMMON_EQUIP: rd_byte = common_equipment_alarms;
        `DSAR_IDX_LATCH_RECEIVE: rd_byte = latched_receive_alarms;
        `DSAR_IDX_LATCH_BUFDEC: rd_byte = latch_bd_reg;
        `DSAR_IDX_LATCH_LOCK: rd_byte = latched_lock_alarms;
        `DSAR_IDX_LATCH_SUPPLY: rd_byte = latched_supply_alarms;
        `DSAR_IDX_LATCH_EQUIP: rd_byte = latched_equipment_alarms;
        `DSAR_IDX_BACKWARD: rd_byte = backward_alarm_flags;
        `DSAR_IDX_RAW_EXP: rd_byte = raw_exp_in;
        `DSAR_IDX_CORR_EXP: rd_byte = corr_exp_in;
        `DSAR_IDX_PAT_EXP: rd_byte = pat_exp_in;
        `DSAR_IDX_FREQ_SIGN: rd_byte = frequency_offset_sign;
        `DSAR_IDX_QUALITY: rd_byte = quality_measure_status;
        `DSAR_IDX_BUF_FILL: rd_byte = buffer_fill_percent;
        `DSAR_IDX_INPUT_LEVEL: rd_byte = input_level_in;
        default: rd_byte = `DSAR_RESET_BYTE;
      endcase
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_data <= `DSAR_RESET_BYTE;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= rd_en;
      // rd_data keeps the last byte read until the next request
      if (rd_en)
        rd_data <= rd_byte;
    end
  end

endmodule // dsar_status_bank

// ==== dsar_regs.vh ====
`ifndef DSAR_REGS_VH
`define DSAR_REGS_VH

// Byte index of each field in the status record, multibyte fields MSB first
`define DSAR_IDX_CLOCK_ACTIVITY 6'h00
`define DSAR_IDX_COMMON_SUPPLY 6'h01
`define DSAR_IDX_COMMON_EQUIP 6'h02
`define DSAR_IDX_LATCH_RECEIVE 6'h03
`define DSAR_IDX_LATCH_BUFDEC 6'h04
`define DSAR_IDX_LATCH_LOCK 6'h05
`define DSAR_IDX_LATCH_SUPPLY 6'h06
`define DSAR_IDX_LATCH_EQUIP 6'h07
`define DSAR_IDX_BACKWARD 6'h08
`define DSAR_IDX_BIT_ERR_CNT 6'h09
`define DSAR_IDX_PAT_ERR_CNT 6'h0d
`define DSAR_IDX_RAW_MANT 6'h11
`define DSAR_IDX_CORR_MANT 6'h13
`define DSAR_IDX_ENERGY_PER_BIT_ESTIMATE 6'h15
`define DSAR_IDX_FREQ_MAG 6'h17
`define DSAR_IDX_PAT_MANT 6'h1b
`define DSAR_IDX_RAW_EXP 6'h1d
`define DSAR_IDX_CORR_EXP 6'h1e
`define DSAR_IDX_PAT_EXP 6'h1f
`define DSAR_IDX_FREQ_SIGN 6'h20
`define DSAR_IDX_QUALITY 6'h21
`define DSAR_IDX_BUF_FILL 6'h22
`define DSAR_IDX_INPUT_LEVEL 6'h23
`define DSAR_RECORD_LAST 6'h23

// Clock activity byte fields
`define DSAR_ACT_BUFFER 0
`define DSAR_ACT_EXT_CONN 1
`define DSAR_ACT_RX_SAT 2
`define DSAR_ACT_INSERT 3
`define DSAR_ACT_EXT_REF 4
`define DSAR_ACT_HS_REF 5
`define DSAR_ACT_FALLBACK 6
`define DSAR_ACT_ENERGY_PER_BIT_ESTIMATE_THR 7

// Misc fields
`define DSAR_RX_DATA_ACTIVITY 6
`define DSAR_RX_GAIN_LEVEL 7
`define DSAR_FILL_MAX 8'h64
`define DSAR_RESET_BYTE 8'h00
`define DSAR_RESET_WORD 32'h00000000

// Activity detection interval
`define DSAR_ACT_INTERVAL_NS 10000
`define DSAR_CLK_PERIOD_NS 20
`define DSAR_ACT_INTERVAL_CYC (`DSAR_ACT_INTERVAL_NS / `DSAR_CLK_PERIOD_NS)

`endif

// ==== dsar_status_bank_asserts.sv ====
`timescale 1ns/1ps
module dsar_checker (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Read port
  input wire rd_en,
  input wire [5:0] rd_index,
  input wire [7:0] rd_data,
  input wire rd_valid,
  // Sources
  input wire intermediate_rate_service,
  input wire [2:0] supply_fail,
  input wire battery_fail,
  input wire memory_fail,
  input wire mc_proc_fault,
  input wire freq_negative_in,
  input wire rates_valid_in,
  input wire pat_rate_valid_in,
  input wire [1:0] energy_per_bit_estimate_status_in,
  input wire err_cnt_overflow_in,
  input wire pat_cnt_overflow_in,
  input wire [7:0] buffer_fill_in,
  input wire [7:0] input_level_in
);
  wire [4:0] sup = {memory_fail, battery_fail, supply_fail};
  wire [5:0] qual = {pat_cnt_overflow_in, err_cnt_overflow_in, energy_per_bit_estimate_status_in,
    pat_rate_valid_in, rates_valid_in};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////////
  property p_supply;
    rd_en && rd_index == 6'h01 && $stable(sup) |=>
      rd_data == {2'b00, $past(sup[4:3]), 1'b0, $past(sup[2:0])};
  endproperty
  a_supply: assert property (p_supply) else $error("supply byte wrong");
  property p_equip;
    rd_en && rd_index == 6'h02 && $stable(mc_proc_fault) |=>
      rd_data[7:3] == 5'h00 && rd_data[0] == $past(mc_proc_fault);
  endproperty
  a_equip: assert property (p_equip) else $error("equipment byte wrong");
  property p_backward;
    rd_en && rd_index == 6'h08 && !intermediate_rate_service |=> rd_data[7:1] == 7'h00;
  endproperty
  a_backward: assert property (p_backward) else $error("backward byte wrong");
  property p_sign;
    rd_en && rd_index == 6'h20 && $stable(freq_negative_in) |=>
      (rd_data != 8'h00) == $past(freq_negative_in);
  endproperty
  a_sign: assert property (p_sign) else $error("sign byte wrong");
  property p_valid_bits;
    rd_en && rd_index == 6'h21 && $stable(qual) |=> rd_data[1:0] == $past(qual[1:0]);
  endproperty
  a_valid_bits: assert property (p_valid_bits) else $error("valid bits wrong");
  property p_est_status;
    rd_en && rd_index == 6'h21 && $stable(qual) |=> rd_data[3:2] == $past(qual[3:2]);
  endproperty
  a_est_status: assert property (p_est_status) else $error("estimate status wrong");
  property p_overflow;
    rd_en && rd_index == 6'h21 && $stable(qual) |=> rd_data[7:4] == {2'b00, $past(qual[5:4])};
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow bits wrong");
  property p_fill;
    rd_en && rd_index == 6'h22 |=> rd_data <= 8'h64;
  endproperty
  a_fill: assert property (p_fill) else $error("fill above 100");
  property p_level;
    rd_en && rd_index == 6'h23 && $stable(input_level_in) |=> rd_data == $past(input_level_in);
  endproperty
  a_level: assert property (p_level) else $error("input level wrong");
  property p_read_answer;
    rd_en |=> rd_valid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_read_pulse;
    !rd_en |=> !rd_valid;
  endproperty
  a_read_pulse: assert property (p_read_pulse) else $error("read answer without request");
  c_quality: cover property (rd_en && rd_index == 6'h21 && qual[3:2] == 2'h3);
  c_clamp: cover property (rd_en && rd_index == 6'h22 && buffer_fill_in > 8'h64);
  c_backward: cover property (rd_en && rd_index == 6'h08 && intermediate_rate_service);
endmodule // dsar_checker
bind dsar_status_bank dsar_checker dsar_checker_i (.*);

// ==== dsar_host_model.sv ====
`timescale 1ns/1ps
module dsar_host_model (
  // Clock
  input wire clk,
  // Read port
  output logic rd_en,
  output logic [5:0] rd_index,
  input wire [7:0] rd_data,
  input wire rd_valid,
  // Latch clear
  output logic latch_clear
);
  initial
  begin
    rd_en = 1'b0;
    rd_index = 6'h00;
    latch_clear = 1'b0;
  end
  // Index is scrambled once the request is over
  task automatic read_byte(input logic [5:0] idx, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge clk);
    rd_en <= 1'b1;
    rd_index <= idx;
    @(posedge clk);
    rd_en <= 1'b0;
    rd_index <= ~idx;
    for (int n = 0; n < 4 && !ok; n++)
    begin
      @(posedge clk);
      ok = rd_valid;
      d = rd_data;
    end
  endtask
  task automatic clear_latches;
    @(posedge clk);
    latch_clear <= 1'b1;
    @(posedge clk);
    latch_clear <= 1'b0;
  endtask
endmodule // dsar_host_model

// ==== dsar_status_bank_bench.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %0t: got %h expected %h", $time, g, e); end end
module dsar_status_bank_bench;
  logic clk = 1'b0, rst = 1'b1, legacy_mode = 1'b0, intermediate_rate_service = 1'b0;
  logic rx_clk_fallback = 1'b0, energy_per_bit_estimate_threshold_fault = 1'b0, buffer_clk_in = 1'b0;
  logic ext_conn_clk_in = 1'b0, rx_sat_clk_in = 1'b0, insert_clk_in = 1'b0;
  logic ext_ref_clk_in = 1'b0, hs_ref_clk_in = 1'b0, battery_fail = 1'b0, memory_fail = 1'b0;
  logic mc_proc_fault = 1'b0, uio_card_present = 1'b1, if_card_present = 1'b1;
  logic freq_negative_in = 1'b0, rates_valid_in = 1'b0, pat_rate_valid_in = 1'b0;
  logic err_cnt_overflow_in = 1'b0, pat_cnt_overflow_in = 1'b0;
  logic [7:0] rx_alarm_live = 8'h40, buffer_decoder_alarms = 8'h00, lock_status = 8'hff;
  logic [7:0] raw_exp_in = 8'hf9, corr_exp_in = 8'h07, pat_exp_in = 8'h05;
  logic [7:0] buffer_fill_in = 8'h32, input_level_in = 8'h9c;
  logic [2:0] supply_fail = 3'h0;
  logic [3:0] backward_alarm_in = 4'hf;
  logic [1:0] energy_per_bit_estimate_status_in = 2'h0, tcnt = 2'h0;
  logic [15:0] raw_mant_in = 16'h0380, corr_mant_in = 16'h1234, pat_mant_in = 16'h0042;
  logic [15:0] energy_per_bit_estimate_in = 16'h02bc;
  logic [31:0] bit_error_count_in = 32'hdeadbeef, pattern_error_count_in = 32'h00000011;
  logic [31:0] freq_mag_in = 32'h01234567;
  logic [5:0] tog_mask = 6'h00;
  wire rd_en, rd_valid, latch_clear;
  wire [5:0] rd_index;
  wire [7:0] rd_data;
  int n_fail = 0, samples_checked = 0;
  dsar_status_bank #(.ACT_INTERVAL(8)) dsar_status_bank_i (.*);
  dsar_host_model dsar_host_model_i (.*);
  initial
  begin
    forever #10 clk = ~clk;
  end
  // Monitored clocks toggle every two cycles under the mask
  always @(posedge clk)
  begin
    tcnt <= tcnt + 2'h1;
    {hs_ref_clk_in, ext_ref_clk_in, insert_clk_in, rx_sat_clk_in, ext_conn_clk_in,
      buffer_clk_in} <= tog_mask & {6{tcnt[1]}};
  end
  //////////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("Comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic rd(input logic [5:0] idx, input logic [7:0] exp, input logic [7:0] msk = 8'hff);
    logic [7:0] d;
    logic ok;
    dsar_host_model_i.read_byte(idx, d, ok);
    if (!ok)
    begin
      $display("Error %0t: read timed out", $time);
      n_fail++;
      close_out();
    end
    else `CHK(d & msk, exp)
  endtask
  task automatic rd_word(input logic [5:0] idx, input int n, input logic [31:0] w);
    for (int i = 0; i < n; i++) rd(idx + 6'(i), w[8 * (n - 1 - i) +: 8]);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(6'h04, 8'h00);
    tog_mask <= 6'h3f;
    rx_clk_fallback <= 1'b1;
    energy_per_bit_estimate_threshold_fault <= 1'b1;
    repeat (30) @(posedge clk);
    rd(6'h00, 8'hff);
    legacy_mode <= 1'b1;
    repeat (30) @(posedge clk);
    rd(6'h00, 8'hcd);
    rd(6'h02, 8'h04);
    tog_mask <= 6'h00;
    rx_clk_fallback <= 1'b0;
    energy_per_bit_estimate_threshold_fault <= 1'b0;
    legacy_mode <= 1'b0;
    repeat (30) @(posedge clk);
    rd(6'h00, 8'h00);
    @(posedge clk);
    {buffer_decoder_alarms, rx_alarm_live, lock_status} <= 24'ha58000;
    {uio_card_present, if_card_present, mc_proc_fault, supply_fail, memory_fail} <= 7'h1b;
    @(posedge clk);
    {buffer_decoder_alarms, rx_alarm_live, lock_status} <= 24'h0040ff;
    {uio_card_present, if_card_present, mc_proc_fault, supply_fail, memory_fail} <= 7'h60;
    rd(6'h04, 8'ha5);
    rd(6'h03, 8'h40);
    rd(6'h05, 8'h87, 8'h87);
    rd(6'h07, 8'h07);
    legacy_mode <= 1'b1;
    rd(6'h07, 8'h05);
    legacy_mode <= 1'b0;
    rd(6'h02, 8'h06);
    rd(6'h06, 8'h25);
    rd(6'h01, 8'h00);
    @(posedge clk);
    buffer_decoder_alarms <= 8'h01;
    dsar_host_model_i.clear_latches();
    buffer_decoder_alarms <= 8'h00;
    rd(6'h04, 8'h01);
    rd(6'h03, 8'h00);
    rd_word(6'h11, 2, 32'h0380);
    rd(6'h1d, 8'hf9);
    rd_word(6'h09, 4, 32'hdeadbeef);
    rd_word(6'h0d, 4, 32'h00000011);
    rd_word(6'h13, 2, 32'h1234);
    rd_word(6'h1b, 2, 32'h0042);
    rd(6'h1e, 8'h07);
    rd(6'h1f, 8'h05);
    rd_word(6'h15, 2, 32'h02bc);
    rd_word(6'h17, 4, 32'h01234567);
    rd(6'h20, 8'h00);
    freq_negative_in <= 1'b1;
    rd(6'h20, 8'h01);
    for (int s = 0; s < 4; s++)
    begin
      {energy_per_bit_estimate_status_in, pat_rate_valid_in, rates_valid_in} <= {2'(s), 2'(s)};
      {pat_cnt_overflow_in, err_cnt_overflow_in} <= {~s[0], s[0]};
      rd(6'h21, {2'b00, ~s[0], s[0], 2'(s), 2'(s)});
    end
    rd(6'h08, 8'h01);
    intermediate_rate_service <= 1'b1;
    rd(6'h08, 8'h0f);
    buffer_fill_in <= 8'hc8;
    rd(6'h22, 8'h64);
    rd(6'h23, 8'h9c);
    rd(6'h3f, 8'h00);
    close_out();
  end
endmodule // dsar_status_bank_bench
